// File: test/spimsc_chk.sv
`timescale 1ns/1ps
module spimsc_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic sclk_oe,
  input wire logic data_oe,
  input wire logic [1:0] select_pins,
  input wire logic select_oe,
  input wire logic done_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire ctl_wr = reg_wr && reg_addr == 6'h00;
  wire sel_wr = reg_wr && reg_addr == 6'h08 && !reg_wdata[3];
  ////////////////////////////////////////
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_go_quiet; ctl_wr && reg_wdata[0] && !done_irq |=> !done_irq [*2]; endproperty
  a_go_quiet: assert property (p_go_quiet) else $error("done right after start");
  property p_irq_clear; ctl_wr && reg_wdata[16] && !reg_wdata[0] |-> ##2 !done_irq; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("done not cleared by write one");
  property p_irq_en_off; ctl_wr && !reg_wdata[17] |-> ##2 !done_irq; endproperty
  a_irq_en_off: assert property (p_irq_en_off) else $error("irq while disabled");
  property p_irq_hold; done_irq && !ctl_wr |=> done_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
  property p_sel_manual;
    sel_wr |-> ##2 select_pins == ($past(reg_wdata[2], 2) ? $past(reg_wdata[1:0], 2) : ~$past(reg_wdata[1:0], 2));
  endproperty
  a_sel_manual: assert property (p_sel_manual) else $error("select pins not following");
  property p_reset_idle; $rose(reset_n) |-> select_pins == 2'b11 && !done_irq && reg_rdata == 32'h0; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_oe_pair; select_oe == sclk_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables disagree");
  property p_data_oe; sclk_oe |-> data_oe; endproperty
  a_data_oe: assert property (p_data_oe) else $error("master data not driven");
endmodule

bind spimsc_top spimsc_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_oe(sclk_oe),
  .data_oe(data_oe), .select_pins(select_pins), .select_oe(select_oe), .done_irq(done_irq));

// File: test/spimsc_peer.sv
`timescale 1ns/1ps
// Off-chip slave: samples on rising clock, shifts on falling clock
module spimsc_peer (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic [31:0] tx_word,
  output logic miso,
  output logic [63:0] rx_q
);
  logic [31:0] tx_q;
  initial begin
    tx_q = 32'h0;
    rx_q = 64'h0;
  end
  always @(negedge sel_n) tx_q <= tx_word;
  always @(posedge sclk) if (!sel_n) rx_q <= {rx_q[62:0], mosi};
  // Rotate so a second word repeats the pattern
  always @(negedge sclk) if (!sel_n) tx_q <= {tx_q[30:0], tx_q[31]};
  // Released line shows the inverse so stale data never looks valid
  assign miso = sel_n ? ~tx_q[31] : tx_q[31];
endmodule

// File: test/tb_spi_master_slave_controller.sv
`timescale 1ns/1ps
`include "spimsc_defs.svh"
module tb_spi_master_slave_controller;
  localparam logic [31:0] PW = 32'hc5a3_0f01;
  logic ref_clk, reset_n, reg_wr, reg_rd, sclk_in, sclk_out, sclk_oe, data_in, data_out, data_oe;
  logic select_in, select_oe, done_irq;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0] select_pins;
  logic [63:0] peer_rx;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  spimsc_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .select_in(select_in),
    .select_pins(select_pins), .select_oe(select_oe), .done_irq(done_irq));
  spimsc_peer peer (.sclk(sclk_out), .sel_n(select_pins[0]), .mosi(data_out), .tx_word(PW), .miso(data_in),
    .rx_q(peer_rx));
  ////////////////////////////////////////
  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = v[31-i];
    return r;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task rc(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v & m);
  endtask
  task wait_done(output logic [31:0] v);
    int n;
    n = 0;
    v = 32'h1;
    while (v[0] !== 1'b0 && n < 400) begin
      rd(`SPIMSC_OFS_CTL, v);
      n++;
    end
    chk("go", 32'h0, {31'h0, v[0]});
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Worst case is about 620 cycles of traffic
  initial begin
    #800000;
    failures++;
    print_verdict;
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sclk_in = 1'b0;
    select_in = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk("pins", 32'h3, {30'h0, select_pins});
    rc("ctl", `SPIMSC_OFS_CTL, 32'h00ff_ffff, 32'h0000_0004);
    rc("div", `SPIMSC_OFS_DIV, 32'hffff_ffff, 32'h0);
    rc("sel", `SPIMSC_OFS_SEL, 32'hffff_ffff, 32'h0);
    rc("rx0", `SPIMSC_OFS_RX0, 32'hffff_ffff, 32'h0);
    rc("rx1", `SPIMSC_OFS_RX1, 32'hffff_ffff, 32'h0);
    rc("tx0", `SPIMSC_OFS_TX0, 32'hffff_ffff, 32'h0);
    rc("pat", `SPIMSC_OFS_PAT, 32'hffff_ffff, 32'h007f_ff87);
    rc("dma", `SPIMSC_OFS_DMA, 32'hffff_ffff, 32'h0);
    wr(`SPIMSC_OFS_PAT, 32'h1234_abcd);
    wr(`SPIMSC_OFS_DMA, 32'h0000_0003);
    wr(6'h0c, 32'hffff_ffff);
    rc("pat", `SPIMSC_OFS_PAT, 32'hffff_ffff, 32'h1234_abcd);
    rc("dma", `SPIMSC_OFS_DMA, 32'h0000_0003, 32'h0000_0003);
    rc("hole", 6'h0c, 32'hffff_ffff, 32'h0);
    // Single byte, MSB first, drive on fall, sample on rise
    wr(`SPIMSC_OFS_SEL, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk("pins", 32'h2, {30'h0, select_pins});
    wr(`SPIMSC_OFS_DIV, 32'h1);
    wr(`SPIMSC_OFS_TX0, 32'h0000_00a5);
    wr(`SPIMSC_OFS_CTL, 32'h0002_0045);
    wr(`SPIMSC_OFS_DIV, 32'h5);
    wait_done(d);
    chk("ctl", 32'h0003_0044, d & 32'h0003_ffff);
    chk("irq", 32'h1, {31'h0, done_irq});
    rc("div", `SPIMSC_OFS_DIV, 32'hffff_ffff, 32'h1);
    rc("rx0", `SPIMSC_OFS_RX0, 32'h0000_00ff, {24'h0, PW[31:24]});
    chk("peer", 32'ha5, {24'h0, peer_rx[7:0]});
    wr(`SPIMSC_OFS_CTL, 32'h0001_0004);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", 32'h0, {31'h0, done_irq});
    // Two 32-bit words, LSB first
    wr(`SPIMSC_OFS_SEL, 32'h0);
    wr(`SPIMSC_OFS_SEL, 32'h1);
    wr(`SPIMSC_OFS_TX0, 32'h1234_5678);
    wr(`SPIMSC_OFS_TX1, 32'h9abc_def0);
    wr(`SPIMSC_OFS_CTL, 32'h0000_0505);
    wait_done(d);
    chk("full", 32'h0, d & 32'h0a00_0000);
    chk("w0", rev32(32'h1234_5678), peer_rx[63:32]);
    chk("w1", rev32(32'h9abc_def0), peer_rx[31:0]);
    rc("rx0", `SPIMSC_OFS_RX0, 32'hffff_ffff, rev32(PW));
    rc("rx1", `SPIMSC_OFS_RX1, 32'hffff_ffff, rev32(PW));
    // Two swapped 32-bit words, MSB first, gap length 1 between bytes, one cycle per half period
    wr(`SPIMSC_OFS_DIV, 32'h0);
    wr(`SPIMSC_OFS_CTL, 32'h001b_1105);
    cyc = 0;
    while (done_irq !== 1'b1 && cyc < 2000) begin
      @(posedge ref_clk);
      #1 cyc++;
    end
    // One cycle to arm, 128 bit half periods, seven gaps each five half periods longer
    chk("cycles", 32'h0000_00a4, cyc);
    chk("sw0", 32'h7856_3412, peer_rx[63:32]);
    chk("sw1", 32'hf0de_bc9a, peer_rx[31:0]);
    rc("rx0", `SPIMSC_OFS_RX0, 32'hffff_ffff, 32'h010f_a3c5);
    rc("rx1", `SPIMSC_OFS_RX1, 32'hffff_ffff, 32'h010f_a3c5);
    // Slave with level-triggered select; external clock runs at one sixth of ours
    wr(`SPIMSC_OFS_SEL, 32'h10);
    wr(`SPIMSC_OFS_TX0, 32'h0000_0096);
    wr(`SPIMSC_OFS_CTL, 32'h0007_0045);
    select_in <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (3) @(posedge ref_clk);
      if (!sclk_in) d = {d[30:0], data_out};
      sclk_in <= ~sclk_in;
    end
    chk("slave tx", 32'h96, {24'h0, d[7:0]});
    wait_done(d);
    chk("irq", 32'h1, {31'h0, done_irq});
    rc("frame", `SPIMSC_OFS_SEL, 32'h0000_0020, 32'h0000_0020);
    rc("rx0", `SPIMSC_OFS_RX0, 32'h0000_00ff, {24'h0, {8{~PW[31]}}});
    print_verdict;
  end
endmodule

// File: verilog/spimsc_clkgen.sv
`timescale 1ns/1ps
// Half-period tick source; a full serial clock period is (div + 1) * 2 cycles
module spimsc_clkgen #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [DIV_W-1:0] half_div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  assign tick = run && (cnt_q >= half_div);
  assign cnt_d = (!run || tick) ? '0 : cnt_q + 1'b1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: verilog/spimsc_defs.svh
`ifndef SPIMSC_DEFS_SVH
`define SPIMSC_DEFS_SVH

// Register byte offsets
`define SPIMSC_OFS_CTL 6'h00
`define SPIMSC_OFS_DIV 6'h04
`define SPIMSC_OFS_SEL 6'h08
`define SPIMSC_OFS_RX0 6'h10
`define SPIMSC_OFS_RX1 6'h14
`define SPIMSC_OFS_TX0 6'h20
`define SPIMSC_OFS_TX1 6'h24
`define SPIMSC_OFS_PAT 6'h34
`define SPIMSC_OFS_DMA 6'h38

// Reset values and control write mask
`define SPIMSC_RST_CTL 32'h0000_0004
`define SPIMSC_RST_DIV 32'h0000_0000
`define SPIMSC_RST_SEL 5'h00
`define SPIMSC_RST_PAT 32'h007f_ff87
`define SPIMSC_CTL_WMASK 32'h10be_fffe

// control_status fields
`define SPIMSC_B_GO 0
`define SPIMSC_B_SMP_FALL 1
`define SPIMSC_B_DRV_FALL 2
`define SPIMSC_F_WBITS 7:3
`define SPIMSC_F_WCNT 9:8
`define SPIMSC_B_LSB 10
`define SPIMSC_B_IDLE 11
`define SPIMSC_F_GAP 15:12
`define SPIMSC_B_DONE 16
`define SPIMSC_B_IEN 17
`define SPIMSC_B_SLAVE 18
`define SPIMSC_B_BGAP 19
`define SPIMSC_B_SWAP 20
`define SPIMSC_B_QUEUE 21
`define SPIMSC_B_VAR 23
`define SPIMSC_B_RXE 24
`define SPIMSC_B_RXF 25
`define SPIMSC_B_TXE 26
`define SPIMSC_B_TXF 27
`define SPIMSC_B_DMASS 28

// select_control fields
`define SPIMSC_F_SLINES 1:0
`define SPIMSC_B_SPOL 2
`define SPIMSC_B_SAUTO 3
`define SPIMSC_B_SLEVEL 4
`define SPIMSC_B_FRAME_OK 5

`endif

// File: verilog/spimsc_pkg.sv
package spimsc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_SHIFT, ST_GAP, ST_STALL} spimsc_state_t;
endpackage

// File: verilog/spimsc_top.sv
`timescale 1ns/1ps
`include "spimsc_defs.svh"
// Overview of operation
// - Writing one to transfer_go starts a transfer; hardware clears it at the end.
// - Register writes are ignored while a transfer runs, except queued transmit data and the queue bit during a stall.
// - word_bits gives 1 to 31 bits per word; zero means 32.
// - word_count 00 carries one word, 01 carries two.
// - drive_on_fall picks the serial clock edge that changes outgoing data.
// - sample_on_fall picks the serial clock edge that captures incoming data.
// - sclk_idle_level sets the idle level of the serial clock.
// - low_bit_first sends bit 0 first, else the top valid bit.
// - Master inserts word_gap_len plus two clock periods between words.
// - With byte_gap_en and 32-bit words, the same gap also separates the bytes within a word.
// - byte_swap_en reverses byte order of sent and received words.
// - var_clock_en lets the pattern choose between both dividers per half period.
// - Pattern bits from bit 31 down choose primary or alternate divider.
// - Serial clock is peripheral clock over (primary_div + 1) times two.
// - alternate_div gives a second rate by the same formula.
// - done_flag sets at transfer end, interrupts if enabled, clears by writing one.
// - buffer_queue_en adds a queue stage to the transmit path and a valid flag to the receive path.
// - Read-only full and empty flags report both queues.
// - In queue mode, missing transmit data stalls; a new write resumes.
// - dma_auto_select_en holds select active through a DMA transaction.
// - Select lines follow select_lines, or with select_auto pulse per word, per byte with byte_gap_en.
// - select_polarity sets the active level of the select signals.
// - Slave select input is edge-triggered, or level-triggered with select_level_mode.
// - level_frame_ok reads one only when word and bit counts matched.
// - Two-word transfers send transmit_data_0 before transmit_data_1.
module spimsc_top
  import spimsc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  input wire logic select_in,
  output logic [1:0] select_pins,
  output logic select_oe,
  output logic done_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] bpos(input logic [5:0] n, input logic lsb, input logic [5:0] k);
    logic [5:0] p;
    p = lsb ? k : n - 6'd1 - k;
    return p[4:0];
  endfunction

  function automatic logic [31:0] bswap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and fields

  spimsc_state_t st_q;
  spimsc_state_t st_d;
  logic [31:0] cfg_q;
  logic [31:0] div_q;
  logic [31:0] pat_q;
  logic [1:0] dma_q;
  logic [4:0] sel_q;
  logic go_q;
  logic done_q;
  logic frame_ok_q;
  logic [31:0] tx0_q;
  logic [31:0] tx1_q;
  logic [31:0] txq0_q;
  logic [31:0] txq1_q;
  logic txq_v_q;
  logic [31:0] rx0_q;
  logic [31:0] rx1_q;
  logic rxq_v_q;
  logic [31:0] rdata_q;

  logic word_q;
  logic [5:0] bit_q;
  logic [5:0] txi_q;
  logic [5:0] rxi_q;
  logic [4:0] hidx_q;
  logic first_q;
  logic [31:0] shw_q;
  logic [31:0] rxw_q;
  logic dout_q;
  logic sclk_q;
  logic prev_q;
  logic sel_prev_q;
  logic [5:0] gap_q;
  logic gap_new_q;
  logic gap_w_q;
  logic [1:0] sel_out_q;

  wire [4:0] wbits = cfg_q[`SPIMSC_F_WBITS];
  wire [5:0] n_bits = (wbits == 5'h00) ? 6'd32 : {1'b0, wbits};
  wire two_words = cfg_q[8];
  wire drv_fall = cfg_q[`SPIMSC_B_DRV_FALL];
  wire smp_fall = cfg_q[`SPIMSC_B_SMP_FALL];
  wire lsb_first = cfg_q[`SPIMSC_B_LSB];
  wire idle_lvl = cfg_q[`SPIMSC_B_IDLE];
  wire [3:0] gap_len = cfg_q[`SPIMSC_F_GAP];
  wire slave = cfg_q[`SPIMSC_B_SLAVE];
  wire queue_en = cfg_q[`SPIMSC_B_QUEUE];
  wire swap_en = cfg_q[`SPIMSC_B_SWAP];
  wire spol = sel_q[`SPIMSC_B_SPOL];
  wire level_mode = sel_q[`SPIMSC_B_SLEVEL];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire wr_ok = reg_wr && !go_q;
  wire wr_ctl = wr_ok && (reg_addr == `SPIMSC_OFS_CTL);
  wire start_req = wr_ctl && reg_wdata[`SPIMSC_B_GO];
  wire done_clr = wr_ctl && reg_wdata[`SPIMSC_B_DONE];
  wire wr_tx0 = reg_wr && (reg_addr == `SPIMSC_OFS_TX0);
  wire wr_tx1 = reg_wr && (reg_addr == `SPIMSC_OFS_TX1);
  // Queue takes transmit data even while busy, one of two exceptions to the write lock
  wire q_wr = go_q && queue_en && (wr_tx0 || wr_tx1);
  wire rx_pop = reg_rd && (reg_addr == `SPIMSC_OFS_RX0);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock and edge events

  logic tick;
  wire [DIV_W-1:0] half_div = (cfg_q[`SPIMSC_B_VAR] && st_q == ST_SHIFT && pat_q[~hidx_q])
                              ? div_q[31:16] : div_q[DIV_W-1:0];

  spimsc_clkgen #(.DIV_W(DIV_W)) u_clkgen (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(!slave && (st_q == ST_SHIFT || st_q == ST_GAP)),
    .half_div(half_div),
    .tick(tick)
  );

  // Slave edges need the external clock well below ours; no filtering is done
  wire in_shift = (st_q == ST_SHIFT);
  wire edge_ev = in_shift && (slave ? (sclk_in != prev_q) : tick);
  wire new_lvl = slave ? sclk_in : !sclk_q;
  wire trail = edge_ev && (new_lvl == idle_lvl);
  wire drv_ev = edge_ev && (new_lvl != drv_fall);
  wire smp_ev = edge_ev && (new_lvl != smp_fall);
  wire word_end = trail && (bit_q + 6'd1 == n_bits);
  wire last_word = (word_q == two_words);
  wire fin = word_end && last_word;
  wire byte_pause = !slave && trail && cfg_q[`SPIMSC_B_BGAP] && wbits == 5'h00
                    && bit_q[2:0] == 3'd7 && !word_end;
  wire sel_act = (select_in == spol);
  wire sel_start = level_mode ? sel_act : (sel_act && !sel_prev_q);
  wire abort = slave && level_mode && in_shift && !sel_act;
  wire [5:0] gap_last = {1'b0, gap_len, 1'b0} + 6'd2;
  wire q_load = queue_en && txq_v_q && (st_q == ST_STALL || (in_shift && (fin || abort)));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic do_load;
  logic load_w;
  logic go_clr;

  always_comb begin
    st_d = st_q;
    do_load = 1'b0;
    load_w = 1'b0;
    go_clr = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // Arm first so the load sees the configuration written with the go bit
        if (start_req) begin
          st_d = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!slave || sel_start) begin
          st_d = ST_SHIFT;
          do_load = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (fin || abort) begin
          if (!queue_en) begin
            st_d = ST_IDLE;
            go_clr = 1'b1;
          end else if (txq_v_q) begin
            st_d = slave ? ST_ARM : ST_GAP;
          end else begin
            st_d = ST_STALL;
          end
        end else if (word_end) begin
          st_d = slave ? ST_SHIFT : ST_GAP;
          do_load = slave;
          load_w = 1'b1;
        end else if (byte_pause) begin
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tick && gap_q == gap_last) begin
          st_d = ST_SHIFT;
          do_load = gap_new_q;
          load_w = gap_w_q;
        end
      end
      ST_STALL: begin
        if (txq_v_q) begin
          st_d = slave ? ST_ARM : ST_GAP;
        end else if (!queue_en) begin
          st_d = ST_IDLE;
          go_clr = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  wire [31:0] ld_raw = load_w ? tx1_q : tx0_q;
  wire [31:0] ld_word = swap_en ? bswap(ld_raw) : ld_raw;
  wire [5:0] txi_nx = txi_q + 6'd1;

  logic [31:0] rxw_nx;
  always_comb begin
    rxw_nx = rxw_q;
    if (smp_ev) begin
      rxw_nx[bpos(n_bits, lsb_first, rxi_q)] = data_in;
    end
  end
  wire [31:0] rx_store = swap_en ? bswap(rxw_nx) : rxw_nx;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      go_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      go_q <= (go_q && !go_clr) || start_req;
      done_q <= (done_q && !done_clr) || (in_shift && (fin || abort));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift datapath

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= 1'b0;
      bit_q <= 6'd0;
      txi_q <= 6'd0;
      rxi_q <= 6'd0;
      hidx_q <= 5'd0;
      first_q <= 1'b1;
      shw_q <= 32'h0000_0000;
      rxw_q <= 32'h0000_0000;
      dout_q <= 1'b0;
      sclk_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (do_load) begin
      word_q <= load_w;
      bit_q <= 6'd0;
      txi_q <= 6'd0;
      rxi_q <= 6'd0;
      hidx_q <= 5'd0;
      first_q <= 1'b1;
      shw_q <= ld_word;
      rxw_q <= 32'h0000_0000;
      dout_q <= ld_word[bpos(n_bits, lsb_first, 6'd0)];
      sclk_q <= idle_lvl;
      prev_q <= sclk_in;
    end else if (edge_ev) begin
      prev_q <= sclk_in;
      sclk_q <= new_lvl;
      hidx_q <= hidx_q + 5'd1;
      first_q <= 1'b0;
      rxw_q <= rxw_nx;
      if (trail) begin
        bit_q <= bit_q + 6'd1;
      end
      // The very first edge never advances data: bit 0 is already on the line
      if (drv_ev && !first_q) begin
        txi_q <= txi_nx;
        dout_q <= shw_q[bpos(n_bits, lsb_first, txi_nx)];
      end
      if (smp_ev) begin
        rxi_q <= rxi_q + 6'd1;
      end
    end else begin
      prev_q <= sclk_in;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 6'd0;
      gap_new_q <= 1'b0;
      gap_w_q <= 1'b0;
    end else if (st_q != ST_GAP) begin
      gap_q <= 6'd0;
      gap_new_q <= !byte_pause || !in_shift;
      gap_w_q <= in_shift && word_end && !last_word;
    end else if (tick) begin
      gap_q <= gap_q + 6'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx0_q <= 32'h0000_0000;
      rx1_q <= 32'h0000_0000;
      frame_ok_q <= 1'b0;
    end else begin
      if (in_shift && word_end && !word_q) begin
        rx0_q <= rx_store;
      end
      if (in_shift && word_end && word_q) begin
        rx1_q <= rx_store;
      end
      if (in_shift && level_mode && slave && (fin || abort)) begin
        frame_ok_q <= fin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `SPIMSC_RST_CTL;
      div_q <= `SPIMSC_RST_DIV;
      pat_q <= `SPIMSC_RST_PAT;
      sel_q <= `SPIMSC_RST_SEL;
      dma_q <= 2'b00;
    end else if (wr_ctl) begin
      cfg_q <= reg_wdata & `SPIMSC_CTL_WMASK;
    end else if (wr_ok && reg_addr == `SPIMSC_OFS_DIV) begin
      div_q <= reg_wdata;
    end else if (wr_ok && reg_addr == `SPIMSC_OFS_SEL) begin
      sel_q <= reg_wdata[4:0];
    end else if (wr_ok && reg_addr == `SPIMSC_OFS_PAT) begin
      pat_q <= reg_wdata;
    end else if (wr_ok && reg_addr == `SPIMSC_OFS_DMA) begin
      dma_q <= reg_wdata[1:0];
    end else if (reg_wr && st_q == ST_STALL && reg_addr == `SPIMSC_OFS_CTL) begin
      // Only way to end a stalled queue run
      cfg_q[`SPIMSC_B_QUEUE] <= reg_wdata[`SPIMSC_B_QUEUE];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx0_q <= 32'h0000_0000;
      tx1_q <= 32'h0000_0000;
      txq0_q <= 32'h0000_0000;
      txq1_q <= 32'h0000_0000;
      txq_v_q <= 1'b0;
      rxq_v_q <= 1'b0;
    end else begin
      if (q_load) begin
        tx0_q <= txq0_q;
        tx1_q <= txq1_q;
      end else if (!go_q && wr_tx0) begin
        tx0_q <= reg_wdata;
      end else if (!go_q && wr_tx1) begin
        tx1_q <= reg_wdata;
      end
      if (q_wr && wr_tx0) begin
        txq0_q <= reg_wdata;
      end
      if (q_wr && wr_tx1) begin
        txq1_q <= reg_wdata;
      end
      txq_v_q <= (txq_v_q && !q_load) || q_wr;
      rxq_v_q <= (rxq_v_q && !rx_pop) || (queue_en && in_shift && (fin || abort));
    end
  end

  wire [31:0] ctl_rd = (cfg_q & `SPIMSC_CTL_WMASK)
                       | {3'b000, 1'b0, queue_en && txq_v_q, !txq_v_q, rxq_v_q, !rxq_v_q, 8'h00, 16'h0000}
                       | {15'h0000, done_q, 15'h0000, go_q};

  logic [31:0] rd_val;
  always_comb begin
    if (reg_addr == `SPIMSC_OFS_CTL) begin
      rd_val = ctl_rd;
    end else if (reg_addr == `SPIMSC_OFS_DIV) begin
      rd_val = div_q;
    end else if (reg_addr == `SPIMSC_OFS_SEL) begin
      rd_val = {26'h000_0000, frame_ok_q, sel_q};
    end else if (reg_addr == `SPIMSC_OFS_RX0) begin
      rd_val = rx0_q;
    end else if (reg_addr == `SPIMSC_OFS_RX1) begin
      rd_val = rx1_q;
    end else if (reg_addr == `SPIMSC_OFS_PAT) begin
      rd_val = pat_q;
    end else if (reg_addr == `SPIMSC_OFS_DMA) begin
      rd_val = {30'h0000_0000, dma_q};
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  wire auto_sel = sel_q[`SPIMSC_B_SAUTO];
  wire dma_hold = cfg_q[`SPIMSC_B_DMASS] && (dma_q != 2'b00);
  // Automatic select drops in every gap, byte gaps included, unless dma_hold keeps it active
  wire sel_on = !auto_sel || in_shift || dma_hold;
  wire [1:0] sel_act_v = sel_q[`SPIMSC_F_SLINES] & {2{sel_on}};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_out_q <= 2'b11;
      sel_prev_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      sel_out_q <= spol ? sel_act_v : ~sel_act_v;
      sel_prev_q <= sel_act;
      rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign sclk_out = (in_shift || st_q == ST_GAP) ? sclk_q : idle_lvl;
  assign sclk_oe = !slave;
  assign data_out = dout_q;
  assign data_oe = !slave || (go_q && sel_act);
  assign select_pins = sel_out_q;
  assign select_oe = !slave;
  assign done_irq = done_q && cfg_q[`SPIMSC_B_IEN];

endmodule
